//--- rsp_pkg.sv
package rsp_pkg;

    // operating mode field encodings
    localparam logic [1:0] MODE_CONV    = 2'h3;  // conversion
    localparam logic [1:0] MODE_STANDBY = 2'h2;  // converter held in reset
    localparam logic [1:0] MODE_SHDN_HI = 2'h1;  // shutdown alias

    // reset values of the configuration bits
    localparam logic REF_SEL_RST  = 1'h0;  // external reference after reset
    localparam logic AUTOZERO_RST = 1'h1;  // auto-zero on after reset
    localparam logic [1:0] MODE_RST = 2'h0;  // shutdown after reset

    // detection time for a supply crossing
    localparam int CLK_MHZ      = 100;
    localparam int DETECT_NS    = 1000;
    localparam int DETECT_CYC   = (DETECT_NS * CLK_MHZ) / 1000;  // longest time: round down
    localparam int DCNT_W       = 8;
    localparam logic [DCNT_W-1:0] DETECT_CYC_W = DCNT_W'(DETECT_CYC);

    // power-on reset sequencing states, gray along the normal path
    typedef enum logic [1:0] {
        RSP_ST_POR   = 2'b00,  // held in power-on reset
        RSP_ST_WAIT  = 2'b01,  // supplies up, waiting for chip select high
        RSP_ST_ARMED = 2'b11,  // port reset, waiting for chip select fall
        RSP_ST_RUN   = 2'b10   // normal operation
    } rsp_state_t;

    // configuration carried together
    typedef struct packed {
        logic       ref_sel;            // 1 internal buffered, 0 external
        logic       reference_autozero_enable;
        logic [1:0] mode;               // operating mode field
    } rsp_cfg_t;

    // reference control outputs
    typedef struct packed {
        logic buf_power;    // reference buffer powered
        logic pin_oe_n;     // positive_reference_pin driven when low
        logic az_run;       // auto-zero step strobe
    } rsp_ref_t;

endpackage : rsp_pkg

//--- rsp_ref_por.sv
module rsp_ref_por (
    input  wire logic              clk_i,           // 100 MHz
    input  wire logic              rst_i,           // synchronous, active high
    input  wire logic              ce_i,            // clock enable, freezes state when low
    input  wire logic              avdd_good_i,     // analog monitor: above threshold
    input  wire logic              dvdd_good_i,     // digital monitor: above threshold
    input  wire logic              collapse_i,      // extremely low supply detector
    input  wire logic              full_shdn_i,     // full shutdown active
    input  wire logic              cs_n_i,          // chip select pin
    input  wire logic              decimation_clock_tick_i,    // decimation clock tick, same domain
    input  wire logic              cfg_we_i,        // write strobe for configuration
    input  wire rsp_pkg::rsp_cfg_t cfg_wdata_i,     // configuration write data
    output logic                   por_o,           // power-on reset state
    output logic                   spi_en_o,        // serial port enabled
    output logic                   spi_reset_o,     // one-cycle serial port reset
    output logic                   por_irq_n_o,     // power-on reset interrupt, low active
    output rsp_pkg::rsp_cfg_t      cfg_o,           // current configuration
    output rsp_pkg::rsp_ref_t      ref_o            // reference control
);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers: pins pass two flops before any logic

    logic [1:0] av_s_r, dv_s_r, cl_s_r, cs_s_r;  // stage 0 feeds stage 1 only
    logic [1:0] av_s_nxt, dv_s_nxt, cl_s_nxt, cs_s_nxt;
    logic       cs_d_r, cs_d_nxt;                // previous synced chip select

    // shift in pin levels
    always_comb begin
        av_s_nxt = {av_s_r[0], avdd_good_i};
        dv_s_nxt = {dv_s_r[0], dvdd_good_i};
        cl_s_nxt = {cl_s_r[0], collapse_i};
        cs_s_nxt = {cs_s_r[0], cs_n_i};
        cs_d_nxt = cs_s_r[1];
    end

    // register the synchronisers; reset treats supplies as down
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            av_s_r <= 2'h0;
            dv_s_r <= 2'h0;
            cl_s_r <= 2'h0;
            cs_s_r <= 2'h3;
            cs_d_r <= 1'h1;
        end else if (ce_i) begin
            av_s_r <= av_s_nxt;
            dv_s_r <= dv_s_nxt;
            cl_s_r <= cl_s_nxt;
            cs_s_r <= cs_s_nxt;
            cs_d_r <= cs_d_nxt;
        end
    end

    logic av_ok, dv_ok, collapse, cs_hi, cs_rise, cs_fall;
    assign av_ok    = av_s_r[1];
    assign dv_ok    = dv_s_r[1];
    assign collapse = cl_s_r[1];
    assign cs_hi    = cs_s_r[1];
    assign cs_rise  = cs_hi & ~cs_d_r;
    assign cs_fall  = ~cs_hi & cs_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // supply fault decision

    logic supply_bad;  // monitors report a low supply, or a collapse in full shutdown
    // in full shutdown the monitors are off; only a collapse counts
    always_comb begin
        if (full_shdn_i) begin
            supply_bad = collapse;
        end else begin
            supply_bad = ~(av_ok & dv_ok);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-on reset sequencer

    rsp_pkg::rsp_state_t st_r, st_nxt;
    logic                irq_r, irq_nxt;   // interrupt pending, high active
    logic                srst_r, srst_nxt; // serial port reset pulse

    // the fault path leaves every state in one edge, so the stop is immediate;
    // release goes through WAIT so defaults and port enable share one edge
    always_comb begin
        st_nxt   = st_r;
        irq_nxt  = irq_r;
        srst_nxt = 1'b0;
        if (supply_bad) begin
            st_nxt  = rsp_pkg::RSP_ST_POR;
            irq_nxt = 1'b1;
        end else begin
            unique case (st_r)
                rsp_pkg::RSP_ST_POR: begin
                    st_nxt = rsp_pkg::RSP_ST_WAIT;
                end
                rsp_pkg::RSP_ST_WAIT: begin
                    // a high level is needed; a low held from reset waits
                    if (cs_hi) begin
                        st_nxt   = rsp_pkg::RSP_ST_ARMED;
                        srst_nxt = cs_rise | (cs_d_r & cs_hi);
                    end
                end
                rsp_pkg::RSP_ST_ARMED: begin
                    if (cs_fall) begin
                        st_nxt  = rsp_pkg::RSP_ST_RUN;
                        irq_nxt = 1'b0;
                    end
                end
                rsp_pkg::RSP_ST_RUN: begin
                    if (cs_rise) begin
                        srst_nxt = 1'b1;
                    end
                end
            endcase
        end
    end

    // register sequencer state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r   <= rsp_pkg::RSP_ST_POR;
            irq_r  <= 1'b1;
            srst_r <= 1'b0;
        end else if (ce_i) begin
            st_r   <= st_nxt;
            irq_r  <= irq_nxt;
            srst_r <= srst_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration bits: cleared to defaults while in reset

    rsp_pkg::rsp_cfg_t cfg_r, cfg_nxt;
    logic              por_r;   // registered reset state output
    logic              spi_en_r;

    // writes are only executed once the port is enabled
    always_comb begin
        cfg_nxt = cfg_r;
        if (st_r == rsp_pkg::RSP_ST_POR) begin
            cfg_nxt.ref_sel                   = rsp_pkg::REF_SEL_RST;
            cfg_nxt.reference_autozero_enable = rsp_pkg::AUTOZERO_RST;
            cfg_nxt.mode                      = rsp_pkg::MODE_RST;
        end else if (cfg_we_i && spi_en_r) begin
            cfg_nxt = cfg_wdata_i;
        end
    end

    // register configuration and port state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r    <= '{ref_sel: rsp_pkg::REF_SEL_RST,
                          reference_autozero_enable: rsp_pkg::AUTOZERO_RST,
                          mode: rsp_pkg::MODE_RST};
            por_r    <= 1'b1;
            spi_en_r <= 1'b0;
        end else if (ce_i) begin
            cfg_r    <= cfg_nxt;
            por_r    <= (st_nxt == rsp_pkg::RSP_ST_POR);
            spi_en_r <= (st_nxt != rsp_pkg::RSP_ST_POR);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reference buffer and auto-zero control

    logic active_mode;  // standby or conversion
    rsp_pkg::rsp_ref_t ref_r, ref_nxt;

    // limitation: buffer power follows the requested mode, not settled state
    always_comb begin
        active_mode = (cfg_r.mode == rsp_pkg::MODE_CONV) |
                      (cfg_r.mode == rsp_pkg::MODE_STANDBY);
        ref_nxt.buf_power = cfg_r.ref_sel & active_mode & ~por_r;
        ref_nxt.pin_oe_n  = ~cfg_r.ref_sel;
        ref_nxt.az_run    = ref_nxt.buf_power & decimation_clock_tick_i &
                            cfg_r.reference_autozero_enable;
    end

    // register reference outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_r <= '{buf_power: 1'b0, pin_oe_n: 1'b1, az_run: 1'b0};
        end else if (ce_i) begin
            ref_r <= ref_nxt;
        end
    end

    assign por_o       = por_r;
    assign spi_en_o    = spi_en_r;
    assign spi_reset_o = srst_r;
    assign por_irq_n_o = ~irq_r;
    assign cfg_o       = cfg_r;
    assign ref_o       = ref_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [rsp_pkg::DCNT_W-1:0] fault_wait_r;    // enabled cycles a fault has waited
    logic [rsp_pkg::DCNT_W-1:0] fault_wait_nxt;  // next wait count

    // watch helper: counts while a synced fault has not yet reached the reset
    // output; it saturates so a stuck fault can never wrap back to a pass
    always_comb begin
        fault_wait_nxt = fault_wait_r;
        if (!supply_bad || por_r) begin
            fault_wait_nxt = '0;
        end else if (fault_wait_r != rsp_pkg::DETECT_CYC_W) begin
            fault_wait_nxt = fault_wait_r + 1'b1;
        end
    end

    // register the watch count; frozen with the rest of the state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_wait_r <= '0;
        end else if (ce_i) begin
            fault_wait_r <= fault_wait_nxt;
        end
    end

    // a fault never waits out the whole detection budget
    a_detect_budget: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_wait_r != rsp_pkg::DETECT_CYC_W)
        else $error("supply fault outlived the detection time");

    // a bad supply reaches the reset output within the detection time
    a_fault_reaches_por: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && supply_bad) |=> por_o)
        else $error("reset state not entered after supply fault");

    // a low supply takes the port down on the next enabled edge
    a_port_off_por: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && supply_bad) |=> (!spi_en_o && por_o))
        else $error("serial port enabled during reset");

    // defaults are in place on the first enabled cycle
    a_defaults_release: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(spi_en_o) |-> (cfg_o.mode == 2'h0 && cfg_o.reference_autozero_enable
                             && !cfg_o.ref_sel))
        else $error("defaults missing at release");

    // release only after both monitors good for a cycle, or in full shutdown
    a_release_both: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(por_o) |-> $past(av_ok && dv_ok) || full_shdn_i)
        else $error("released with a supply low");

    // por and port enable switch on the same edge
    a_release_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(por_o) |-> $rose(spi_en_o))
        else $error("reset release and port enable split");

    // buffer off in shutdown modes
    a_buf_off_shdn: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !cfg_o.mode[1]) |=> !ref_o.buf_power)
        else $error("reference buffer powered in shutdown");

    // pin direction tracks the select bit
    a_pin_dir: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> (ref_o.pin_oe_n == !$past(cfg_o.ref_sel)))
        else $error("reference pin direction wrong");

    // no auto-zero steps when disabled
    a_az_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !cfg_o.reference_autozero_enable) |=> !ref_o.az_run)
        else $error("auto-zero ran while disabled");

    // chip select fall in armed state clears the interrupt
    a_irq_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && st_r == rsp_pkg::RSP_ST_ARMED && cs_fall && !supply_bad)
        |=> por_irq_n_o)
        else $error("interrupt not cleared on chip select fall");

    // internal reference in standby or conversion powers the buffer
    a_buf_on_active: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && cfg_o.ref_sel && cfg_o.mode[1] && !por_o) |=> ref_o.buf_power)
        else $error("reference buffer off in an active mode");

    // auto-zero steps follow the decimation tick when enabled
    a_az_on: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && decimation_clock_tick_i && cfg_o.reference_autozero_enable && cfg_o.ref_sel
         && cfg_o.mode[1] && !por_o) |=> ref_o.az_run)
        else $error("auto-zero step missed on a tick");

    // chip select high after release resets the serial port
    a_port_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && st_r == rsp_pkg::RSP_ST_WAIT && cs_hi && !supply_bad) |=> spi_reset_o)
        else $error("serial port reset missing after release");

    // in full shutdown only a collapse may enter the reset state
    a_shdn_no_por: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && full_shdn_i && !collapse && !por_o) |=> !por_o)
        else $error("reset entered in full shutdown without a collapse");

endmodule : rsp_ref_por

//--- rsp_host_model.sv
// behavioural host on the serial port: chip select and configuration writes
module rsp_host_model (
    input  wire logic              clk_i,        // 100 MHz
    input  wire logic              rst_i,        // synchronous, active high
    input  wire logic              spi_en_i,     // port enabled by the device
    input  wire logic              req_i,        // bench asks for one write
    input  wire rsp_pkg::rsp_cfg_t req_cfg_i,    // value to write
    output logic                   cs_n_o,       // chip select, low active
    output logic                   cfg_we_o,     // write strobe
    output rsp_pkg::rsp_cfg_t      cfg_wdata_o,  // write data
    output logic                   ready_o       // port usable
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] phase_r;  // steps since the port came up

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cs_n_o = 1'b0;
        cfg_we_o = 1'b0;
        cfg_wdata_o = '0;
        ready_o = 1'b0;
        phase_r = 4'h0;
    end

    // chip select stays low through reset, the awkward case for the port
    always @(posedge clk_i) begin
        if (rst_i || !spi_en_i) begin
            phase_r <= 4'h0;
            cs_n_o <= 1'b0;
            ready_o <= 1'b0;
            cfg_we_o <= 1'b0;
            cfg_wdata_o <= ~cfg_wdata_o;  // idle data toggles, never holds
        end else begin
            if (phase_r != 4'hF) begin
                phase_r <= phase_r + 4'h1;
            end
            cs_n_o <= (phase_r < 4'h6);
            ready_o <= (phase_r >= 4'hE);
            cfg_we_o <= req_i & ready_o;
            cfg_wdata_o <= (req_i & ready_o) ? req_cfg_i : ~cfg_wdata_o;
        end
    end
endmodule : rsp_host_model

//--- tb_rsp_ref_por.sv
module tb_rsp_ref_por;
    timeunit 1ns;
    timeprecision 1ns;

    logic              clk_i, rst_i, ce, avdd, dvdd, collapse, full_shdn;
    logic              cs_n, tick, we, req, por, spi_en, spi_rst, irq_n, ready;
    rsp_pkg::rsp_cfg_t wdata, req_cfg, cfg, c;
    rsp_pkg::rsp_ref_t refo;
    int                errors, check_count, seed, resets, cycles;

    rsp_ref_por rsp_ref_por_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .avdd_good_i(avdd),
        .dvdd_good_i(dvdd), .collapse_i(collapse), .full_shdn_i(full_shdn), .cs_n_i(cs_n),
        .decimation_clock_tick_i(tick), .cfg_we_i(we), .cfg_wdata_i(wdata), .por_o(por),
        .spi_en_o(spi_en), .spi_reset_o(spi_rst), .por_irq_n_o(irq_n), .cfg_o(cfg),
        .ref_o(refo));
    rsp_host_model rsp_host_model_i (.clk_i(clk_i), .rst_i(rst_i), .spi_en_i(spi_en),
        .req_i(req), .req_cfg_i(req_cfg), .cs_n_o(cs_n), .cfg_we_o(we),
        .cfg_wdata_o(wdata), .ready_o(ready));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // expected reference outputs for a configuration
    function automatic rsp_pkg::rsp_ref_t exp_ref(input rsp_pkg::rsp_cfg_t x);
        return '{buf_power: x.ref_sel & x.mode[1], pin_oe_n: ~x.ref_sel, az_run: 1'b0};
    endfunction : exp_ref

    task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc

    // bounded wait for the host to finish its chip select handshake
    task automatic wait_ready;
        int k;
        k = 0;
        while (ready !== 1'b1 && k < 300) begin
            @(posedge clk_i);
            k++;
        end
        #1 check({3'h0, ready}, 4'h1, "host ready");
    endtask : wait_ready

    // one write, then the outputs it steers and one auto-zero tick
    task automatic write_chk(input rsp_pkg::rsp_cfg_t x);
        @(posedge clk_i) req <= 1'b1;
        req_cfg <= x;
        @(posedge clk_i) req <= 1'b0;
        cyc(2);
        #1 check(cfg, x, "configuration");
        check({1'b0, refo}, {1'b0, exp_ref(x)}, "reference control");
        @(posedge clk_i) tick <= 1'b1;
        @(posedge clk_i) tick <= 1'b0;
        #1 check({3'h0, refo.az_run}, {3'h0, x.ref_sel & x.mode[1] & x[2]}, "auto-zero");
    endtask : write_chk

    // cycle ceiling, port reset pulses and the joint release of reset
    always @(posedge clk_i) begin
        cycles++;
        if (spi_rst === 1'b1) resets++;
        if (!rst_i) check({3'h0, por ^ spi_en}, 4'h1, "port versus reset");
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {errors, check_count, resets, cycles} = '0;
        seed = 40;
        {rst_i, ce, avdd, dvdd, collapse, full_shdn, tick, req} = 8'hC0;
        req_cfg = '0;
        cyc(2);
        rst_i <= 1'b0;
        cyc(1);
        #1 check(cfg, {rsp_pkg::REF_SEL_RST, rsp_pkg::AUTOZERO_RST, rsp_pkg::MODE_RST},
            "reset configuration");
        check({por, spi_en, irq_n, 1'b0}, 4'h8, "reset state");
        check({1'b0, refo}, 4'h2, "reset reference");
        @(posedge clk_i) avdd <= 1'b1;
        cyc(20);
        #1 check({2'h0, por, spi_en}, 4'h2, "one supply up");
        @(posedge clk_i) dvdd <= 1'b1;
        wait_ready();
        check({2'h0, por, spi_en}, 4'h1, "both supplies up");
        check({3'h0, irq_n}, 4'h1, "interrupt cleared");
        check(4'(resets), 4'h1, "port reset pulses");
        // every encoding, then random ones; a low ratio is assumed, so auto-zero may clear
        for (int i = 0; i < 24; i++) begin
            c = (i < 16) ? 4'(i) : 4'($random(seed));
            write_chk(c);
        end
        // clock enable low freezes the synchronisers: a supply dip goes unseen
        @(posedge clk_i) ce <= 1'b0;
        dvdd <= 1'b0;
        cyc(6);
        #1 check({2'h0, por, spi_en}, 4'h1, "frozen by clock enable");
        @(posedge clk_i) ce <= 1'b1;
        dvdd <= 1'b1;
        cyc(3);
        #1 check(cfg, c, "configuration after freeze");
        // one supply falls in mid-run, with a non-default configuration held
        @(posedge clk_i) dvdd <= 1'b0;
        cyc(3);
        #1 check({2'h0, por, spi_en}, 4'h2, "supply fall");
        cyc(1);
        #1 check(cfg, {rsp_pkg::REF_SEL_RST, rsp_pkg::AUTOZERO_RST, rsp_pkg::MODE_RST},
            "defaults after fall");
        @(posedge clk_i) dvdd <= 1'b1;
        wait_ready();
        check(4'(resets), 4'h2, "port reset again");
        // full shutdown ignores the monitors but not a collapse
        @(posedge clk_i) full_shdn <= 1'b1;
        avdd <= 1'b0;
        cyc(20);
        #1 check({3'h0, por}, 4'h0, "monitor off in shutdown");
        @(posedge clk_i) collapse <= 1'b1;
        cyc(3);
        #1 check({3'h0, por}, 4'h1, "collapse in shutdown");
        finish_test();
    end
endmodule : tb_rsp_ref_por
